/* logic/dmacsa_channel.sv */
// Purpose: One DMA channel in short address mode with its registers.
// Assumes: Triggers are one-cycle pulses synchronous to CLK.
// Notes:   A transfer is announced one cycle after its trigger.
//
// Function
// RULE1: Memory address is 32 bits; top byte reads ones, low 24 bits writable.
// RULE2: Peripheral address register gives the other endpoint in short mode.
// RULE3: In full address mode the peripheral address is ignored.
// RULE4: Select 0-3 timer channel A, 4 transmit empty, 5 receive full.
// RULE5: Select top bits both one means full address mode.
// RULE6: Interrupt enable gates the request raised by transfer enable clearing.
// RULE7: Repeat 0 is I/O, repeat 1 with enable 0 repeat, both idle.
// RULE8: Direction zero steps the address up by one or two.
// RULE9: Direction one steps the address down by one or two.
// RULE10: Transfer enable allows transfers; all control bits reset to zero.
// RULE11: A 16-bit read/write transfer count, high and low bytes.
// RULE12: Count drops per transfer; I/O mode clears enable at zero.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
module dmacsa_channel #(
    parameter int MEM_W = dmacsa_pkg::MEM_ADDR_W
) (
    input  wire logic                               CLK,
    input  wire logic                               RESET_N,
    input  wire logic [dmacsa_pkg::REG_ADDR_W-1:0]  REG_ADDR,
    input  wire logic [dmacsa_pkg::DATA_W-1:0]      REG_WDATA,
    input  wire logic                               REG_WRITE,
    input  wire logic                               REG_READ,
    output logic      [dmacsa_pkg::DATA_W-1:0]      REG_RDATA,
    input  wire logic [3:0]                         TIMER_MATCH_A,
    input  wire logic                               SERIAL_TX_EMPTY,
    input  wire logic                               SERIAL_RX_FULL,
    output logic                                    XFER_STROBE,
    output logic      [MEM_W-1:0]                   XFER_MEM_ADDR,
    output logic      [7:0]                         XFER_PERIPH_ADDR,
    output logic                                    XFER_WORD,
    output logic                                    FULL_ADDRESS_MODE,
    output logic                                    IRQ
);
    import dmacsa_pkg::*;

    initial begin
        if (MEM_W != MEM_ADDR_W) begin
            $error("dmacsa_channel: memory address must be 24 bits");
        end
    end

    // -----------------------------------------------------------------
    // Registers
    // -----------------------------------------------------------------
    logic [MEM_W-1:0]   mem_addr;
    logic [COUNT_W-1:0] count;
    logic [7:0]         periph_addr;
    logic [7:0]         control;
    logic [ST_W-1:0]    status;
    logic [ST_W-1:0]    mask;

    logic               enable;
    logic               word;
    logic               down;
    logic [2:0]         select;
    logic               full_mode;
    dmacsa_mode_type    mode;

    logic               fire;
    logic               go;
    logic [MEM_W-1:0]   next_mem_addr;
    logic [COUNT_W-1:0] next_count;
    logic               count_zero;
    logic               end_event;

    logic               wr_mar_ext;
    logic               wr_mar_high;
    logic               wr_mar_low;
    logic               wr_cnt_high;
    logic               wr_cnt_low;
    logic               wr_control;

    assign enable = control[BIT_ENABLE];
    assign word   = control[BIT_SIZE];
    assign down   = control[BIT_DIR];
    assign select = control[SEL_HI:SEL_LO];

    // Lowest select bit plays no part once full mode is chosen.
    assign full_mode = (select[SEL_HI:1] == SEL_FULL); // [RULE5]

    always_comb begin
        case ({control[BIT_REPEAT], control[BIT_IRQ_EN]}) // [RULE7]
            2'b10:   mode = DMACSA_REPEAT;
            2'b11:   mode = DMACSA_IDLE;
            default: mode = DMACSA_IO;
        endcase
    end

    assign wr_mar_ext  = REG_WRITE && (REG_ADDR == OFS_MAR_EXT);
    assign wr_mar_high = REG_WRITE && (REG_ADDR == OFS_MAR_HIGH);
    assign wr_mar_low  = REG_WRITE && (REG_ADDR == OFS_MAR_LOW);
    assign wr_cnt_high = REG_WRITE && (REG_ADDR == OFS_CNT_HIGH);
    assign wr_cnt_low  = REG_WRITE && (REG_ADDR == OFS_CNT_LOW);
    assign wr_control  = REG_WRITE && (REG_ADDR == OFS_CONTROL);

    // -----------------------------------------------------------------
    // Trigger and address step
    // -----------------------------------------------------------------
    dmacsa_trigger u_trigger (
        .select      (select),
        .timer_match (TIMER_MATCH_A),
        .tx_empty    (SERIAL_TX_EMPTY),
        .rx_full     (SERIAL_RX_FULL),
        .fire        (fire)
    );

    // Full address mode transfers belong to the paired channel, so this
    // channel starts none of its own while that mode is selected.
    assign go = enable && fire && !full_mode; // [RULE10]

    dmacsa_stepper #(
        .WIDTH (MEM_W)
    ) u_stepper (
        .addr      (mem_addr),
        .word      (word),
        .down      (down),
        .hold      (mode == DMACSA_IDLE),
        .next_addr (next_mem_addr)
    );

    // -----------------------------------------------------------------
    // Transfer count
    // -----------------------------------------------------------------
    // Repeat mode counts in the low byte and reloads it from the high
    // byte, so a block repeats without software help.
    always_comb begin
        next_count = count - COUNT_W'(1); // [RULE12]
        count_zero = (count == COUNT_W'(1));
        if (mode == DMACSA_REPEAT) begin
            count_zero = (count[7:0] == 8'h01);
            next_count = {count[15:8], count[7:0] - 8'h01};
            if (count_zero) begin
                next_count = {count[15:8], count[15:8]};
            end
        end
    end

    assign end_event = go && count_zero && (mode == DMACSA_IO);

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            count <= '0;
        end else if (wr_cnt_high) begin
            count[15:8] <= REG_WDATA; // [RULE11]
        end else if (wr_cnt_low) begin
            count[7:0] <= REG_WDATA; // [RULE11]
        end else if (go) begin
            count <= next_count; // [RULE12]
        end
    end

    // -----------------------------------------------------------------
    // Memory and peripheral addresses
    // -----------------------------------------------------------------
    // Software writes win over a step in the same cycle.
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            mem_addr <= '0;
        end else if (wr_mar_ext) begin
            mem_addr[23:16] <= REG_WDATA; // [RULE1]
        end else if (wr_mar_high) begin
            mem_addr[15:8] <= REG_WDATA; // [RULE1]
        end else if (wr_mar_low) begin
            mem_addr[7:0] <= REG_WDATA; // [RULE1]
        end else if (go) begin
            mem_addr <= next_mem_addr; // [RULE8] [RULE9]
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            periph_addr <= '0;
        end else if (REG_WRITE && (REG_ADDR == OFS_PER_ADDR)) begin
            periph_addr <= REG_WDATA;
        end
    end

    // -----------------------------------------------------------------
    // Control
    // -----------------------------------------------------------------
    // A software write in the same cycle as the end of a block wins, so
    // a restart written at that moment is not lost.
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            control <= CONTROL_RST; // [RULE10]
        end else if (wr_control) begin
            control <= REG_WDATA;
        end else if (end_event) begin
            control[BIT_ENABLE] <= 1'b0; // [RULE12]
        end
    end

    // -----------------------------------------------------------------
    // Transfer announcement
    // -----------------------------------------------------------------
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            XFER_STROBE      <= 1'b0;
            XFER_MEM_ADDR    <= '0;
            XFER_PERIPH_ADDR <= '0;
            XFER_WORD        <= 1'b0;
        end else begin
            XFER_STROBE <= go;
            if (go) begin
                XFER_MEM_ADDR    <= mem_addr;
                XFER_PERIPH_ADDR <= periph_addr; // [RULE2]
                XFER_WORD        <= word;
            end
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            FULL_ADDRESS_MODE <= 1'b0;
        end else begin
            FULL_ADDRESS_MODE <= full_mode; // [RULE3] [RULE5]
        end
    end

    // -----------------------------------------------------------------
    // Interrupts
    // -----------------------------------------------------------------
    // Status bits are sticky and cleared by writing one; an event in the
    // clearing cycle still sets its bit.
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            status <= '0;
        end else begin
            if (REG_WRITE && (REG_ADDR == OFS_STATUS)) begin
                status <= status & ~REG_WDATA[ST_W-1:0];
            end
            if (end_event && control[BIT_IRQ_EN]) begin
                status[ST_END] <= 1'b1; // [RULE6]
            end
            if (go && count_zero) begin
                status[ST_ZERO] <= 1'b1;
            end
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            mask <= '0;
        end else if (REG_WRITE && (REG_ADDR == OFS_MASK)) begin
            mask <= REG_WDATA[ST_W-1:0];
        end
    end

    assign IRQ = |(status & mask);

    // -----------------------------------------------------------------
    // Read port
    // -----------------------------------------------------------------
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            REG_RDATA <= READ_NONE;
        end else if (REG_READ) begin
            case (REG_ADDR)
                OFS_MAR_TOP:  REG_RDATA <= MAR_TOP_READ; // [RULE1]
                OFS_MAR_EXT:  REG_RDATA <= mem_addr[23:16];
                OFS_MAR_HIGH: REG_RDATA <= mem_addr[15:8];
                OFS_MAR_LOW:  REG_RDATA <= mem_addr[7:0];
                OFS_CNT_HIGH: REG_RDATA <= count[15:8];
                OFS_CNT_LOW:  REG_RDATA <= count[7:0];
                OFS_PER_ADDR: REG_RDATA <= periph_addr;
                OFS_CONTROL:  REG_RDATA <= control;
                OFS_STATUS:   REG_RDATA <= {6'h00, status};
                OFS_MASK:     REG_RDATA <= {6'h00, mask};
                default:      REG_RDATA <= READ_NONE;
            endcase
        end else begin
            REG_RDATA <= READ_NONE;
        end
    end

endmodule

/* logic/dmacsa_pkg.sv */
// Purpose: Shared constants for the short address mode DMA channel.
// Assumes: Byte-wide register port with byte addresses.
// Notes:   Memory address register is big-endian over four bytes.
package dmacsa_pkg;

    localparam int          REG_ADDR_W   = 8;
    localparam int          DATA_W       = 8;
    localparam int          MEM_ADDR_W   = 24;
    localparam int          COUNT_W      = 16;

    // -----------------------------------------------------------------
    // Register offsets
    // -----------------------------------------------------------------
    localparam logic [7:0]  OFS_MAR_TOP  = 8'h20;
    localparam logic [7:0]  OFS_MAR_EXT  = 8'h21;
    localparam logic [7:0]  OFS_MAR_HIGH = 8'h22;
    localparam logic [7:0]  OFS_MAR_LOW  = 8'h23;
    localparam logic [7:0]  OFS_CNT_HIGH = 8'h24;
    localparam logic [7:0]  OFS_CNT_LOW  = 8'h25;
    localparam logic [7:0]  OFS_PER_ADDR = 8'h26;
    localparam logic [7:0]  OFS_CONTROL  = 8'h27;
    localparam logic [7:0]  OFS_STATUS   = 8'h28;
    localparam logic [7:0]  OFS_MASK     = 8'h29;

    // -----------------------------------------------------------------
    // Field positions and values
    // -----------------------------------------------------------------
    localparam int          BIT_ENABLE   = 7;
    localparam int          BIT_SIZE     = 6;
    localparam int          BIT_DIR      = 5;
    localparam int          BIT_REPEAT   = 4;
    localparam int          BIT_IRQ_EN   = 3;
    localparam int          SEL_HI       = 2;
    localparam int          SEL_LO       = 0;
    localparam int          ST_END       = 0;
    localparam int          ST_ZERO      = 1;
    localparam int          ST_W         = 2;

    localparam logic [7:0]  MAR_TOP_READ = 8'hFF;
    localparam logic [7:0]  CONTROL_RST  = 8'h00;
    localparam logic [7:0]  READ_NONE    = 8'h00;
    localparam logic [1:0]  SEL_FULL     = 2'h3;
    localparam logic [2:0]  SEL_TX_EMPTY = 3'h4;
    localparam logic [2:0]  SEL_RX_FULL  = 3'h5;

    typedef enum logic [1:0] {
        DMACSA_IO     = 2'h0,
        DMACSA_REPEAT = 2'h1,
        DMACSA_IDLE   = 2'h3
    } dmacsa_mode_type;

endpackage

/* logic/dmacsa_trigger.sv */
// Purpose: Picks the activation source of the channel.
// Assumes: Request inputs are one-cycle pulses, synchronous to CLK.
// Notes:   Select codes six and seven give no trigger.
`timescale 1ns/1ps
module dmacsa_trigger (
    input  wire logic [2:0] select,
    input  wire logic [3:0] timer_match,
    input  wire logic       tx_empty,
    input  wire logic       rx_full,
    output logic            fire
);
    import dmacsa_pkg::*;

    always_comb begin
        fire = 1'b0;
        if (select[SEL_HI] == 1'b0) begin
            fire = timer_match[select[1:0]]; // [RULE4]
        end else if (select == SEL_TX_EMPTY) begin
            fire = tx_empty; // [RULE4]
        end else if (select == SEL_RX_FULL) begin
            fire = rx_full; // [RULE4]
        end
    end

endmodule

/* logic/dmacsa_stepper.sv */
// Purpose: Next memory address after one transfer.
// Assumes: Address wraps modulo its width.
// Notes:   Hold keeps the address fixed, as idle mode needs.
`timescale 1ns/1ps
module dmacsa_stepper #(
    parameter int WIDTH = 24
) (
    input  wire logic [WIDTH-1:0] addr,
    input  wire logic             word,
    input  wire logic             down,
    input  wire logic             hold,
    output logic      [WIDTH-1:0] next_addr
);

    initial begin
        if (WIDTH < 2) begin
            $error("dmacsa_stepper: WIDTH must be at least 2");
        end
    end

    logic [WIDTH-1:0] step;

    always_comb begin
        step = word ? WIDTH'(2) : WIDTH'(1);
        if (hold) begin
            next_addr = addr;
        end else if (down) begin
            next_addr = addr - step; // [RULE9]
        end else begin
            next_addr = addr + step; // [RULE8]
        end
    end

endmodule

/* test/dmacsa_sources.sv */
// Purpose: Model of the timer and serial event sources.
// Assumes: The bench raises fire just after a rising edge.
// Notes:   Codes six and seven fire every source at once.
`timescale 1ns/1ps
module dmacsa_sources (
    input  wire logic       fire,
    input  wire logic [2:0] code,
    output logic      [3:0] timer_match,
    output logic            tx_empty,
    output logic            rx_full
);
    logic all;

    // Sources idle low; a held fire gives back-to-back events.
    always_comb begin
        all         = fire && code[2:1] == 2'h3;
        timer_match = (fire && !code[2]) ? 4'h1 << code[1:0] : {4{all}};
        tx_empty    = (fire && code == 3'h4) || all;
        rx_full     = (fire && code == 3'h5) || all;
    end
endmodule

/* test/dmacsa_channel_sva.sv */
// Purpose: Port assertions for the DMA channel.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes:   Bound to every channel instance.
`timescale 1ns/1ps
module dmacsa_channel_sva #(
    parameter int MEM_W = dmacsa_pkg::MEM_ADDR_W
) (
    input wire logic                              CLK,
    input wire logic                              RESET_N,
    input wire logic [dmacsa_pkg::REG_ADDR_W-1:0] REG_ADDR,
    input wire logic [dmacsa_pkg::DATA_W-1:0]     REG_WDATA,
    input wire logic                              REG_WRITE,
    input wire logic                              REG_READ,
    input wire logic [dmacsa_pkg::DATA_W-1:0]     REG_RDATA,
    input wire logic [3:0]                        TIMER_MATCH_A,
    input wire logic                              SERIAL_TX_EMPTY,
    input wire logic                              SERIAL_RX_FULL,
    input wire logic                              XFER_STROBE,
    input wire logic [MEM_W-1:0]                  XFER_MEM_ADDR,
    input wire logic [7:0]                        XFER_PERIPH_ADDR,
    input wire logic                              XFER_WORD,
    input wire logic                              FULL_ADDRESS_MODE,
    input wire logic                              IRQ
);
    import dmacsa_pkg::*;
    logic       any_req;
    logic [7:0] last_ctl;
    logic [1:0] age;

    assign any_req = (|TIMER_MATCH_A) | SERIAL_TX_EMPTY | SERIAL_RX_FULL;

    // The mode flag may lag a control write, so it is judged two edges on.
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            last_ctl <= CONTROL_RST;
            age      <= 2'h2;
        end else if (REG_WRITE && REG_ADDR == OFS_CONTROL) begin
            last_ctl <= REG_WDATA;
            age      <= 2'h0;
        end else if (age != 2'h2) begin
            age <= age + 2'h1;
        end
    end

    default clocking dc @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    a_read_idle: assert property (!$past(REG_READ) |-> REG_RDATA == READ_NONE)
        else $error("read data not idle");
    a_top_ones: assert property ($past(REG_READ) && $past(REG_ADDR) == OFS_MAR_TOP |-> REG_RDATA == MAR_TOP_READ)
        else $error("top address byte not all ones");
    a_xfer_cause: assert property (XFER_STROBE |-> $past(any_req))
        else $error("transfer without trigger");
    a_full_quiet: assert property (FULL_ADDRESS_MODE && $past(FULL_ADDRESS_MODE) |-> !XFER_STROBE)
        else $error("transfer in full address mode");
    a_hold_out: assert property (!XFER_STROBE |-> $stable(XFER_MEM_ADDR) && $stable(XFER_PERIPH_ADDR) && $stable(XFER_WORD))
        else $error("transfer outputs moved");
    // The announced address trails the register by one edge, so a write
    // that can displace a step was taken two edges back.
    a_addr_step: assert property (XFER_STROBE && $past(XFER_STROBE) && !$past(REG_WRITE, 2) |-> XFER_MEM_ADDR == $past(XFER_MEM_ADDR) || XFER_MEM_ADDR == $past(XFER_MEM_ADDR) + ($past(XFER_WORD) ? MEM_W'(2) : MEM_W'(1)) || XFER_MEM_ADDR == $past(XFER_MEM_ADDR) - ($past(XFER_WORD) ? MEM_W'(2) : MEM_W'(1)))
        else $error("bad address step");
    a_irq_cause: assert property ($rose(IRQ) |-> XFER_STROBE || $past(REG_WRITE))
        else $error("interrupt without cause");
    a_full_flag: assert property (age == 2'h2 |-> FULL_ADDRESS_MODE == (last_ctl[2:1] == SEL_FULL))
        else $error("full mode flag wrong");
endmodule

bind dmacsa_channel dmacsa_channel_sva #(.MEM_W(MEM_W)) dmacsa_channel_sva_inst (
    .CLK(CLK), .RESET_N(RESET_N), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WRITE(REG_WRITE), .REG_READ(REG_READ),
    .REG_RDATA(REG_RDATA), .TIMER_MATCH_A(TIMER_MATCH_A),
    .SERIAL_TX_EMPTY(SERIAL_TX_EMPTY), .SERIAL_RX_FULL(SERIAL_RX_FULL),
    .XFER_STROBE(XFER_STROBE), .XFER_MEM_ADDR(XFER_MEM_ADDR),
    .XFER_PERIPH_ADDR(XFER_PERIPH_ADDR), .XFER_WORD(XFER_WORD),
    .FULL_ADDRESS_MODE(FULL_ADDRESS_MODE), .IRQ(IRQ));

/* test/dmacsa_channel_test.sv */
// Purpose: Self-checking bench for the DMA channel.
// Assumes: The bench is register master; a source model fires triggers.
// Notes:   Addresses, sizes and directions are random from a fixed seed.
`timescale 1ns/1ps
module dmacsa_channel_test;
    import dmacsa_pkg::*;
    logic        clk = 1'b0, reset_n = 1'b0, fire = 1'b0;
    logic        reg_write = 1'b0, reg_read = 1'b0;
    logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, p, px;
    logic [2:0]  code = 3'h0, sel;
    logic [3:0]  tm;
    logic        tx, rx, strobe, word, full, irq, w, dn, ok;
    logic [23:0] xaddr, a, e;
    int          mismatches = 0, checks_done = 0, cycles = 0, n;

    dmacsa_sources dmacsa_sources_inst (.fire(fire), .code(code),
        .timer_match(tm), .tx_empty(tx), .rx_full(rx));
    dmacsa_channel dmacsa_channel_inst (.CLK(clk), .RESET_N(reset_n),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WRITE(reg_write),
        .REG_READ(reg_read), .REG_RDATA(reg_rdata), .TIMER_MATCH_A(tm),
        .SERIAL_TX_EMPTY(tx), .SERIAL_RX_FULL(rx), .XFER_STROBE(strobe),
        .XFER_MEM_ADDR(xaddr), .XFER_PERIPH_ADDR(px), .XFER_WORD(word),
        .FULL_ADDRESS_MODE(full), .IRQ(irq));

    always #5 clk = ~clk;

    // ------------------------------------------------------------
    // Bus tasks and comparisons
    // ------------------------------------------------------------
    task automatic stop_test();
        if (mismatches == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(logic [7:0] ad, logic [7:0] d);
        @(posedge clk);
        reg_addr  <= ad;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask
    task automatic rd_chk(string what, logic [7:0] ad, logic [7:0] exp);
        @(posedge clk);
        reg_addr <= ad;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        @(negedge clk);
        check(what, reg_rdata, exp);
    endtask
    task automatic set_addr(logic [23:0] v);
        wr(OFS_MAR_EXT, v[23:16]);
        wr(OFS_MAR_HIGH, v[15:8]);
        wr(OFS_MAR_LOW, v[7:0]);
    endtask
    task automatic chk_addr(logic [23:0] v);
        rd_chk("mar_ext", OFS_MAR_EXT, v[23:16]);
        rd_chk("mar_high", OFS_MAR_HIGH, v[15:8]);
        rd_chk("mar_low", OFS_MAR_LOW, v[7:0]);
    endtask
    // Holding fire for k cycles gives k back-to-back triggers.
    task automatic trig(logic [2:0] c, int k);
        @(posedge clk);
        fire <= 1'b1;
        code <= c;
        repeat (k) @(posedge clk);
        fire <= 1'b0;
        @(negedge clk);
    endtask
    function automatic logic [23:0] nxt(logic [23:0] v, logic wd, logic d);
        return d ? v - (wd ? 24'h2 : 24'h1) : v + (wd ? 24'h2 : 24'h1);
    endfunction

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            stop_test();
        end
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h0B29));
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        rd_chk("control", OFS_CONTROL, CONTROL_RST);
        wr(OFS_MAR_TOP, 8'h00);
        rd_chk("mar_top", OFS_MAR_TOP, MAR_TOP_READ);
        rd_chk("unmapped", 8'h3C, READ_NONE);
        for (int i = 0; i < 16; i++) begin
            sel = 3'(i);
            {w, dn} = 2'($urandom);
            a = 24'($urandom);
            p = 8'($urandom);
            n = (i % 3 == 0) ? 2 : 1;
            ok = i < 8 && sel < 3'h6;
            set_addr(a);
            wr(OFS_CNT_HIGH, 8'h00);
            wr(OFS_CNT_LOW, 8'h05);
            wr(OFS_PER_ADDR, p);
            rd_chk("periph", OFS_PER_ADDR, p);
            wr(OFS_CONTROL, {i < 8, w, dn, 2'b00, sel});
            trig(sel ^ 3'h1, 1);
            check("wrong_src", strobe, 1'b0);
            trig(sel, n);
            check("strobe", strobe, ok);
            check("full", full, sel[2:1] == 2'h3);
            e = a;
            if (ok) begin
                e = (n == 2) ? nxt(a, w, dn) : a;
                check("xfer_addr", xaddr, e);
                check("xfer_periph", px, p);
                check("word", word, w);
                e = nxt(e, w, dn);
            end
            chk_addr(e);
            rd_chk("count", OFS_CNT_LOW, ok ? 8'(5 - n) : 8'h05);
        end
        wr(OFS_MASK, 8'h01);
        for (int ie = 0; ie < 2; ie++) begin
            wr(OFS_CNT_LOW, 8'h01);
            wr(OFS_CONTROL, {4'h8, ie[0], 3'h4});
            trig(3'h4, 1);
            rd_chk("ctl_end", OFS_CONTROL, {4'h0, ie[0], 3'h4});
            rd_chk("status", OFS_STATUS, {7'h01, ie[0]});
            check("irq", irq, ie[0]);
            wr(OFS_MASK, 8'h00);
            @(negedge clk);
            check("masked", irq, 1'b0);
            wr(OFS_MASK, 8'h01);
            wr(OFS_STATUS, 8'h03);
            rd_chk("cleared", OFS_STATUS, 8'h00);
            check("irq_off", irq, 1'b0);
        end
        for (int m = 0; m < 2; m++) begin
            a = 24'($urandom);
            set_addr(a);
            wr(OFS_CNT_HIGH, 8'h07);
            wr(OFS_CNT_LOW, 8'h01);
            wr(OFS_CONTROL, m ? 8'h98 : 8'h90);
            trig(3'h0, 1);
            rd_chk("mode_ctl", OFS_CONTROL, m ? 8'h98 : 8'h90);
            rd_chk("mode_cnt", OFS_CNT_LOW, m ? 8'h00 : 8'h07);
            chk_addr(m ? a : a + 24'h1);
        end
        stop_test();
    end
endmodule
